// file: hdl/bus_access_config.sv
// bus access configuration and pci command selection for the dma engine
//
// Overview of operation
// [RULE1] write-invalidate enable picks full-line write command
// [RULE2] read-line enable picks read-line at line boundary
// [RULE3] read-multiple enable picks read-multiple for full lines
// [RULE4] suspended transmit polls ownership at programmed interval
// [RULE5] bursts align to 8, 16 or 32 dwords
// [RULE6] software programs alignment after reset before dma
// [RULE7] burst length limited by field, zero unlimited
// [RULE8] csr decode eight-byte then four-byte spacing
// [RULE9] trigger write while suspended fetches tx descriptor
// [RULE10] software stops tx and rx before writing
// [RULE11] reserved bits read zero, ignore writes
`timescale 1ns/1ps
`default_nettype none
module bus_access_config #(
   parameter int poll_short = bus_access_pkg::poll_short_cycles,
   parameter int poll_mid = bus_access_pkg::poll_mid_cycles,
   parameter int poll_long = bus_access_pkg::poll_long_cycles
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic csr_wr,
   input wire logic csr_rd,
   input wire logic [7:0] csr_addr,
   input wire logic [31:0] csr_wdata,
   output logic [31:0] csr_rdata,
   output logic csr_hit,
   input wire logic tx_suspended,
   output logic tx_desc_fetch,
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [31:0] req_addr,
   input wire logic [6:0] req_dwords,
   output logic cmd_valid,
   output logic [3:0] cmd_code,
   output logic [6:0] cmd_dwords
);
   // ------------------------------------------------------------
   // register file
   // ------------------------------------------------------------
   logic [31:0] config_q;
   logic poll_tick;
   logic cfg_sel;
   logic trig_sel;

   // [RULE8] decode of the csr window
   function automatic logic csr_mapped(input logic [7:0] a);
      if (a <= bus_access_pkg::wide_space_last) begin
         return a[2:0] == 3'h0;
      end else if (a >= bus_access_pkg::narrow_space_first &&
                   a <= bus_access_pkg::narrow_space_last) begin
         return a[1:0] == 2'h0;
      end else begin
         return 1'b0;
      end
   endfunction : csr_mapped

   assign cfg_sel = csr_addr == bus_access_pkg::bus_access_config_index;
   assign trig_sel = csr_addr == bus_access_pkg::tx_poll_trigger_off;

   // [RULE11] only documented fields take writes
   always_ff @(posedge mclk) begin
      if (rst) begin
         config_q <= bus_access_pkg::config_reset;
      end else if (csr_wr && cfg_sel) begin
         config_q <= csr_wdata & bus_access_pkg::writable_mask;
      end
   end

   // [RULE8] read data and decode hit
   always_ff @(posedge mclk) begin
      if (rst) begin
         csr_rdata <= 32'h0;
         csr_hit <= 1'b0;
      end else begin
         csr_hit <= (csr_rd || csr_wr) && csr_mapped(csr_addr);
         if (csr_rd && cfg_sel) begin
            csr_rdata <= config_q;
         end else begin
            csr_rdata <= 32'h0;
         end
      end
   end

   // ------------------------------------------------------------
   // transmit descriptor polling
   // ------------------------------------------------------------
   poll_timer #(
      .short_cycles(poll_short),
      .mid_cycles(poll_mid),
      .long_cycles(poll_long)
   ) u_poll (
      .mclk(mclk),
      .rst(rst),
      .mode(config_q[bus_access_pkg::auto_poll_lsb +: 2]),
      .run(tx_suspended),
      .tick(poll_tick)
   );

   // [RULE9] demand write or poll tick starts a fetch, only while tx is suspended
   always_ff @(posedge mclk) begin
      if (rst) begin
         tx_desc_fetch <= 1'b0;
      end else begin
         tx_desc_fetch <= tx_suspended && ((csr_wr && trig_sel) || poll_tick);
      end
   end

   // ------------------------------------------------------------
   // command and burst selection
   // ------------------------------------------------------------
   logic [6:0] line_dw;
   logic [5:0] burst_max;
   logic [6:0] to_boundary;
   logic [6:0] len;
   logic aligned;
   logic full_line;

   // [RULE5] cache line size from alignment field; 00 leaves bursts unaligned
   always_comb begin
      case (config_q[bus_access_pkg::cache_align_lsb +: 2])
         2'h1: line_dw = 7'd8;
         2'h2: line_dw = 7'd16;
         2'h3: line_dw = 7'd32;
         default: line_dw = 7'd0;
      endcase
   end

   assign burst_max = config_q[bus_access_pkg::max_burst_lsb +: 6];

   always_comb begin
      to_boundary = 7'd0;
      aligned = 1'b0;
      len = req_dwords;
      if (line_dw != 7'd0) begin
         to_boundary = line_dw - (req_addr[8:2] & (line_dw - 7'd1));
         aligned = to_boundary == line_dw;
         // [RULE5] a burst never crosses the alignment boundary
         if (len > to_boundary) begin
            len = to_boundary;
         end
      end
      // [RULE7] zero means no limit
      if (burst_max != 6'h0 && len > {1'b0, burst_max}) begin
         len = {1'b0, burst_max};
      end
      full_line = aligned && len == line_dw;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         cmd_valid <= 1'b0;
         cmd_code <= bus_access_pkg::cmd_mem_read;
         cmd_dwords <= 7'h0;
      end else begin
         cmd_valid <= req_valid;
         cmd_dwords <= req_valid ? len : 7'h0;
         if (req_write) begin
            // [RULE1] write-invalidate only for whole lines
            if (config_q[bus_access_pkg::write_invalidate_enable_bit] && full_line) begin
               cmd_code <= bus_access_pkg::cmd_write_invalidate;
            end else begin
               cmd_code <= bus_access_pkg::cmd_mem_write;
            end
         // [RULE3] read multiple for full aligned lines
         end else if (config_q[bus_access_pkg::read_multiple_enable_bit] && full_line) begin
            cmd_code <= bus_access_pkg::cmd_read_multiple;
         // [RULE2] read line when access reaches the line boundary
         end else if (config_q[bus_access_pkg::read_line_enable_bit] && line_dw != 7'd0 &&
                      len == to_boundary) begin
            cmd_code <= bus_access_pkg::cmd_read_line;
         end else begin
            cmd_code <= bus_access_pkg::cmd_mem_read;
         end
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence plain_write_req;
      req_valid && req_write && !config_q[bus_access_pkg::write_invalidate_enable_bit];
   endsequence

   sequence line_write_req;
      req_valid && req_write && full_line &&
         config_q[bus_access_pkg::write_invalidate_enable_bit];
   endsequence

   sequence demand_write;
      tx_suspended && csr_wr && trig_sel;
   endsequence

   chk_reserved_zero: assert property (@(posedge mclk) disable iff (rst) // [RULE11]
      (config_q & ~bus_access_pkg::writable_mask) == 32'h0)
      else $error("reserved config bits not zero");
   chk_write_invalidate_off: assert property (@(posedge mclk) disable iff (rst) // [RULE1]
      plain_write_req |=> cmd_code == bus_access_pkg::cmd_mem_write)
      else $error("write invalidate issued while disabled");
   chk_write_invalidate_on: assert property (@(posedge mclk) disable iff (rst) // [RULE1]
      line_write_req |=> cmd_code == bus_access_pkg::cmd_write_invalidate)
      else $error("full line write used plain write");
   chk_read_line_off: assert property (@(posedge mclk) disable iff (rst) // [RULE2]
      (req_valid && !req_write && !config_q[bus_access_pkg::read_line_enable_bit])
      |=> cmd_code != bus_access_pkg::cmd_read_line)
      else $error("read line issued while disabled");
   chk_read_multiple_gate: assert property (@(posedge mclk) disable iff (rst) // [RULE3]
      (req_valid && !req_write &&
         !(config_q[bus_access_pkg::read_multiple_enable_bit] && full_line))
      |=> cmd_code != bus_access_pkg::cmd_read_multiple)
      else $error("read multiple without full aligned line");
   chk_burst_limit: assert property (@(posedge mclk) disable iff (rst) // [RULE7]
      (req_valid && burst_max != 6'h0) |=> cmd_dwords <= {1'b0, $past(burst_max)})
      else $error("burst exceeds programmed length");
   chk_align_cross: assert property (@(posedge mclk) disable iff (rst) // [RULE5]
      (req_valid && line_dw != 7'd0) |=> cmd_dwords <= $past(to_boundary))
      else $error("burst crosses alignment boundary");
   // a tick launched before the code changed may still come out, so look one edge on
   chk_poll_off: assert property (@(posedge mclk) disable iff (rst) // [RULE4]
      config_q[bus_access_pkg::auto_poll_lsb +: 2] == 2'h0 |=> !poll_tick)
      else $error("poll tick while polling disabled");
   chk_poll_fetch: assert property (@(posedge mclk) disable iff (rst) // [RULE4]
      (poll_tick && tx_suspended) |=> tx_desc_fetch)
      else $error("poll tick did not fetch descriptor");
   chk_demand_fetch: assert property (@(posedge mclk) disable iff (rst) // [RULE9]
      demand_write |=> tx_desc_fetch)
      else $error("demand write did not fetch descriptor");
   chk_unmapped_miss: assert property (@(posedge mclk) disable iff (rst) // [RULE8]
      (csr_rd && csr_addr > bus_access_pkg::narrow_space_last) |=> !csr_hit)
      else $error("unmapped address decoded");
endmodule : bus_access_config
`default_nettype wire

// file: hdl/bus_access_pkg.sv
// constants for the dma bus access configuration block
`default_nettype none
package bus_access_pkg;
   // register map (byte offsets from csr base)
   localparam logic [7:0] bus_access_config_index = 8'h00;
   localparam logic [7:0] tx_poll_trigger_off = 8'h08;
   localparam logic [7:0] wide_space_last = 8'h78;
   localparam logic [7:0] narrow_space_first = 8'h80;
   localparam logic [7:0] narrow_space_last = 8'hb0;
   // bus_access_config field positions
   localparam int write_invalidate_enable_bit = 24;
   localparam int read_line_enable_bit = 23;
   localparam int read_multiple_enable_bit = 21;
   localparam int auto_poll_lsb = 17;
   localparam int cache_align_lsb = 14;
   localparam int max_burst_lsb = 8;
   localparam logic [31:0] writable_mask = 32'h01a6_ff00;
   localparam logic [31:0] config_reset = 32'h0000_0000;
   // pci memory command encodings
   localparam logic [3:0] cmd_mem_read = 4'h6;
   localparam logic [3:0] cmd_mem_write = 4'h7;
   localparam logic [3:0] cmd_read_multiple = 4'hc;
   localparam logic [3:0] cmd_read_line = 4'he;
   localparam logic [3:0] cmd_write_invalidate = 4'hf;
   // auto-poll timing
   localparam int clk_mhz = 40;
   localparam int poll_short_us = 200;
   localparam int poll_mid_us = 800;
   localparam int poll_long_us = 1600;
   localparam int poll_short_cycles = poll_short_us * clk_mhz;
   localparam int poll_mid_cycles = poll_mid_us * clk_mhz;
   localparam int poll_long_cycles = poll_long_us * clk_mhz;
endpackage : bus_access_pkg
`default_nettype wire

// file: hdl/poll_timer.sv
// auto-poll interval timer for the suspended transmit process
`timescale 1ns/1ps
`default_nettype none
module poll_timer #(
   parameter int short_cycles = 8000,
   parameter int mid_cycles = 32000,
   parameter int long_cycles = 64000
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [1:0] mode,
   input wire logic run,
   output logic tick
);
   logic [16:0] count_q;
   logic [16:0] limit;

   always_comb begin
      case (mode)
         2'h1: limit = 17'(short_cycles - 1);
         2'h2: limit = 17'(mid_cycles - 1);
         default: limit = 17'(long_cycles - 1);
      endcase
   end

   // [RULE4] poll interval count
   always_ff @(posedge mclk) begin
      if (rst || !run || mode == 2'h0) begin
         count_q <= 17'h0;
         tick <= 1'b0;
      end else if (count_q >= limit) begin
         count_q <= 17'h0;
         tick <= 1'b1;
      end else begin
         count_q <= count_q + 17'h1;
         tick <= 1'b0;
      end
   end
endmodule : poll_timer
`default_nettype wire

// file: verification/pci_far_model.sv
// far-side model: records the pci commands the dma engine issues
`timescale 1ns/1ps
`default_nettype none
module pci_far_model (
   input wire logic mclk,
   input wire logic cmd_valid,
   input wire logic [3:0] cmd_code,
   input wire logic [6:0] cmd_dwords,
   output logic [3:0] seen_code,
   output logic [6:0] seen_dwords
);
   // the bus side accepts every command at once; no retry is modelled
   always_ff @(posedge mclk) begin
      if (cmd_valid) begin
         seen_code <= cmd_code;
         seen_dwords <= cmd_dwords;
      end
   end
endmodule : pci_far_model
`default_nettype wire

// file: verification/tb_bus_access_config.sv
// self-checking bench for the bus access configuration block
`timescale 1ns/1ps
`default_nettype none
`define chk(got, exp) begin samples_checked++; if ((got) !== (exp)) begin \
   $display("BAD t=%0t got=%h exp=%h", $time, got, exp); err_count++; end end
module tb_bus_access_config;
   logic mclk, rst, csr_wr, csr_rd, tx_suspended, req_valid, req_write;
   logic [7:0] csr_addr;
   logic [31:0] csr_wdata, req_addr, csr_rdata;
   logic [6:0] req_dwords, cmd_dwords, seen_dwords;
   logic csr_hit, tx_desc_fetch, cmd_valid;
   logic [3:0] cmd_code, seen_code;
   int err_count = 0;
   int samples_checked = 0;
   bus_access_config #(.poll_short(10), .poll_mid(20), .poll_long(40)) uut (.mclk(mclk),
      .rst(rst), .csr_wr(csr_wr), .csr_rd(csr_rd), .csr_addr(csr_addr), .csr_wdata(csr_wdata),
      .csr_rdata(csr_rdata), .csr_hit(csr_hit), .tx_suspended(tx_suspended),
      .tx_desc_fetch(tx_desc_fetch), .req_valid(req_valid), .req_write(req_write),
      .req_addr(req_addr), .req_dwords(req_dwords), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .cmd_dwords(cmd_dwords));
   pci_far_model far (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .cmd_dwords(cmd_dwords), .seen_code(seen_code), .seen_dwords(seen_dwords));
   // ----------------------------------------
   // bus tasks
   // ----------------------------------------
   task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      csr_wr <= wr;
      csr_rd <= !wr;
      csr_addr <= a;
      csr_wdata <= d;
      @(posedge mclk);
      csr_wr <= 1'b0;
      csr_rd <= 1'b0;
      #1;
   endtask : access
   task automatic req(input logic w, input logic [31:0] a, input logic [6:0] n,
      input logic [3:0] c, input logic [6:0] g);
      @(posedge mclk);
      req_valid <= 1'b1;
      req_write <= w;
      req_addr <= a;
      req_dwords <= n;
      @(posedge mclk);
      req_valid <= 1'b0;
      #1;
      `chk(cmd_valid, 1'b1)
      `chk(cmd_code, c)
      `chk(cmd_dwords, g)
   endtask : req
   // waits for one poll pulse, then counts cycles to the next one
   task automatic gap(output int n);
      for (int i = 0; i < 200 && tx_desc_fetch !== 1'b1; i++) begin
         @(posedge mclk);
         #1;
      end
      n = 0;
      do begin
         @(posedge mclk);
         #1;
         n++;
      end while (tx_desc_fetch !== 1'b1 && n < 200);
   endtask : gap
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_regs();
      logic [7:0] addrs[8] = '{8'h00, 8'h04, 8'h78, 8'h7c, 8'h80, 8'h84, 8'hb0, 8'hb4};
      logic [7:0] hits = 8'b1010_1110;
      access(1'b0, 8'h00, 32'h0000_0000);
      `chk(csr_rdata, bus_access_pkg::config_reset)
      `chk(cmd_code, bus_access_pkg::cmd_mem_read)
      access(1'b1, 8'h00, 32'hffff_ffff);
      access(1'b0, 8'h00, 32'h0000_0000);
      `chk(csr_rdata, bus_access_pkg::writable_mask)
      for (int i = 0; i < 8; i++) begin
         access(1'b0, addrs[i], 32'h0000_0000);
         `chk(csr_hit, hits[7 - i])
      end
   endtask : t_regs
   task automatic t_cmds();
      access(1'b1, 8'h00, 32'h0100_4000);
      req(1'b1, 32'h40, 7'h08, 4'hf, 7'h08);
      req(1'b1, 32'h44, 7'h04, 4'h7, 7'h04);
      access(1'b1, 8'h00, 32'h0000_4000);
      req(1'b1, 32'h40, 7'h08, 4'h7, 7'h08);
      access(1'b1, 8'h00, 32'h0020_4000);
      req(1'b0, 32'h40, 7'h08, 4'hc, 7'h08);
      req(1'b0, 32'h44, 7'h07, 4'h6, 7'h07);
      access(1'b1, 8'h00, 32'h0080_4000);
      req(1'b0, 32'h44, 7'h07, 4'he, 7'h07);
      req(1'b0, 32'h44, 7'h03, 4'h6, 7'h03);
      req(1'b0, 32'h44, 7'h10, 4'he, 7'h07);
      access(1'b1, 8'h00, 32'h0000_8000);
      req(1'b0, 32'h40, 7'h28, 4'h6, 7'h10);
      access(1'b1, 8'h00, 32'h0000_c000);
      req(1'b0, 32'h80, 7'h28, 4'h6, 7'h20);
      access(1'b1, 8'h00, 32'h0000_c400);
      req(1'b0, 32'h40, 7'h28, 4'h6, 7'h04);
      // the far side latches one edge after the command appears
      @(posedge mclk);
      #1;
      `chk(seen_dwords, 7'h04)
      `chk(seen_code, bus_access_pkg::cmd_mem_read)
      // reserved alignment code: no line, so no clipping and no line commands
      access(1'b1, 8'h00, 32'h01a0_0000);
      req(1'b1, 32'h44, 7'h28, 4'h7, 7'h28);
      req(1'b0, 32'h44, 7'h28, 4'h6, 7'h28);
   endtask : t_cmds
   task automatic t_poll();
      int n;
      int periods[3] = '{10, 20, 40};
      @(posedge mclk);
      tx_suspended <= 1'b1;
      for (int c = 1; c < 4; c++) begin
         access(1'b1, 8'h00, 32'h0000_4000 | (c << bus_access_pkg::auto_poll_lsb));
         gap(n);
         `chk(n, periods[c - 1])
      end
      access(1'b1, 8'h00, 32'h0000_4000);
      gap(n);
      `chk(n, 200)
      access(1'b1, 8'h08, 32'h0000_0000);
      `chk(tx_desc_fetch, 1'b1)
      tx_suspended <= 1'b0;
      access(1'b1, 8'h08, 32'h0000_0000);
      `chk(tx_desc_fetch, 1'b0)
   endtask : t_poll
   task automatic t_reset();
      @(posedge mclk);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      #1;
      `chk(cmd_code, bus_access_pkg::cmd_mem_read)
      `chk(csr_hit, 1'b0)
      access(1'b0, 8'h00, 32'h0000_0000);
      `chk(csr_rdata, bus_access_pkg::config_reset)
   endtask : t_reset
   // ----------------------------------------
   // run control
   // ----------------------------------------
   task automatic close_out();
      $display("checks=%0d errors=%0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : close_out
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   initial begin
      #(25 * 5000);
      err_count++;
      close_out();
   end
   initial begin
      rst = 1'b1;
      {csr_wr, csr_rd, tx_suspended, req_valid, req_write} = 5'h00;
      csr_addr = 8'h00;
      csr_wdata = 32'h0000_0000;
      req_addr = 32'h0000_0000;
      req_dwords = 7'h00;
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      t_regs();
      t_cmds();
      t_poll();
      t_reset();
      close_out();
   end
endmodule : tb_bus_access_config
`default_nettype wire
